// >>> sccd_pkg.sv
package sccd_pkg;

  // Command word layout
  localparam int unsigned CMD_W        = 8;
  localparam int unsigned MISC_LSB     = 4;
  localparam int unsigned MISC_W       = 3;
  localparam int unsigned TXC_LSB      = 2;
  localparam int unsigned RXC_LSB      = 0;
  localparam int unsigned FLD_W        = 2;
  localparam int unsigned ERR_FLAGS_W  = 4;

  // Host register map (word addresses)
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  ADDR_CMD     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h1;
  localparam logic [3:0]  ADDR_MODE    = 4'h2;
  localparam logic [3:0]  ADDR_LAST    = 4'h3;

  // Host status word bit positions
  localparam int unsigned ST_TX_EN     = 0;
  localparam int unsigned ST_RX_EN     = 1;
  localparam int unsigned ST_BREAK     = 2;
  localparam int unsigned ST_BUSY      = 3;

  // Mode word bit positions
  localparam int unsigned MD_MULTIDROP = 0;
  localparam int unsigned MD_LOOPBACK  = 1;

  localparam logic [7:0]  RESET_CMD    = 8'h00;

  // Mark hold after break stop, in bit times
  localparam int unsigned BREAK_BITS   = 2;

  typedef enum logic [2:0] {
    MISC_NONE      = 3'h0,
    MISC_PTR_RESET = 3'h1,
    MISC_RX_RESET  = 3'h2,
    MISC_TX_RESET  = 3'h3,
    MISC_ERR_CLR   = 3'h4,
    MISC_BRK_CLR   = 3'h5,
    MISC_BRK_START = 3'h6,
    MISC_BRK_STOP  = 3'h7
  } sccd_misc_e;

  localparam logic [1:0]  FC_NONE      = 2'h0;
  localparam logic [1:0]  FC_ENABLE    = 2'h1;
  localparam logic [1:0]  FC_DISABLE   = 2'h2;
  localparam logic [1:0]  FC_ILLEGAL   = 2'h3;

endpackage

// >>> sccd_if.sv
`timescale 1ns/1ps
interface sccd_if;
  logic                        cmd_wr;
  logic [sccd_pkg::CMD_W-1:0]  cmd_data;

  modport dev  (input  cmd_wr, input  cmd_data);
  modport host (output cmd_wr, output cmd_data);
endinterface

// >>> sccd_host.sv
`timescale 1ns/1ps
module sccd_host (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Software port
  input  wire logic [sccd_pkg::ADDR_W-1:0]   addr,
  input  wire logic [sccd_pkg::CMD_W-1:0]    wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [sccd_pkg::CMD_W-1:0]    rdata,
  output logic                               illegal_r,
  // Link
  sccd_if.host                               link
);

  typedef struct packed {
    logic                       wr;
    logic [sccd_pkg::CMD_W-1:0] data;
    logic [sccd_pkg::CMD_W-1:0] last;
    logic [sccd_pkg::CMD_W-1:0] rdata;
    logic                       illegal;
  } sccd_host_s;

  sccd_host_s st_r;
  sccd_host_s st_nxt;
  logic       bad;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr = 1'b0;
    st_nxt.rdata = '0;
    bad = 1'b0;
    if (wr && addr == sccd_pkg::ADDR_CMD) begin
      // Drop words with an illegal field or with conflicting actions
      bad = (wdata[sccd_pkg::TXC_LSB +: sccd_pkg::FLD_W] == sccd_pkg::FC_ILLEGAL)
         || (wdata[sccd_pkg::RXC_LSB +: sccd_pkg::FLD_W] == sccd_pkg::FC_ILLEGAL)
         || (wdata[sccd_pkg::MISC_LSB +: sccd_pkg::MISC_W] == sccd_pkg::MISC_TX_RESET
             && wdata[sccd_pkg::TXC_LSB +: sccd_pkg::FLD_W] == sccd_pkg::FC_ENABLE)
         || (wdata[sccd_pkg::MISC_LSB +: sccd_pkg::MISC_W] == sccd_pkg::MISC_RX_RESET
             && wdata[sccd_pkg::RXC_LSB +: sccd_pkg::FLD_W] == sccd_pkg::FC_ENABLE);
      st_nxt.illegal = bad;
      if (!bad) begin
        st_nxt.wr = 1'b1;
        st_nxt.data = wdata;
        st_nxt.last = wdata;
      end
    end
    if (rd && addr == sccd_pkg::ADDR_LAST) begin
      st_nxt.rdata = st_r.last;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.cmd_wr   = st_r.wr;
  assign link.cmd_data = st_r.data;
  assign rdata         = st_r.rdata;
  assign illegal_r     = st_r.illegal;

endmodule

// >>> sccd_dev.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - All fields of one write act together
// - Top command bit is ignored
// - Bits six-four: miscellaneous code, 000 idle
// - Code 001 returns mode pointer to first
// - Code 010 resets receiver, flags and queue
// - Host resets receiver before reconfiguring it
// - Code 011 resets transmitter and its flags
// - Code 100 clears the four error flags
// - Block mode: clear errors before last read
// - Code 101 clears break-change interrupt flag
// - Code 110 starts break, up to one bit late
// - Break waits for pending characters to finish
// - Code 111 marks, held for two bit boundaries, then idle
// - Bits three-two: transmitter command, 00 idle
// - Transmitter code 01 enables transmitter
// - Transmitter code 10 disables after current character
// - Host never writes transmitter code 11
// - Bits one-zero: receiver command, 00 idle
// - Receiver code 01 enables, hunts start unless multidrop
// - Receiver code 10 stops receiver, drops character
// - Host never writes receiver code 11
module sccd_dev #(
  parameter int unsigned BIT_DIV = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Link from host
  sccd_if.dev       link,
  // Channel state seen by the decoder
  input  wire logic multidrop,
  input  wire logic loopback,
  input  wire logic tx_shifting,
  input  wire logic tx_holding,
  input  wire logic tx_serial_in,
  // Action pulses
  output logic      mode_ptr_reset_r,
  output logic      rx_reset_r,
  output logic      receive_ready_flag_clr_r,
  output logic      receive_fifo_full_flag_clr_r,
  output logic      receive_queue_ptr_reset_r,
  output logic      tx_reset_r,
  output logic      transmit_ready_flag_clr_r,
  output logic      transmit_empty_flag_clr_r,
  output logic      error_flags_clr_r,
  output logic      break_change_clr_r,
  output logic      rx_hunt_start_r,
  output logic      rx_discard_r,
  // Levels
  output logic      tx_enable_r,
  output logic      tx_stop_pending_r,
  output logic      rx_enable_r,
  output logic      rx_active_r,
  output logic      tx_hold_mark_r,
  output logic      serial_transmit_output_r
);

  // Divider counter is 16 bits wide
  if (BIT_DIV < 1 || BIT_DIV > 65536) begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  typedef enum logic [3:0] {
    BRK_IDLE  = 4'h1,
    BRK_WAIT  = 4'h2,
    BRK_ON    = 4'h4,
    BRK_MARK  = 4'h8
  } sccd_brk_e;

  typedef struct packed {
    logic [11:0] pulses;
    logic        tx_en;
    logic        tx_stop;
    logic        rx_en;
    logic        rx_act;
    logic        mark;
    logic        txd;
    sccd_brk_e   brk;
    logic [1:0]  bits;
    logic [15:0] div;
  } sccd_dev_s;

  sccd_dev_s  st_r;
  sccd_dev_s  st_nxt;
  logic [2:0] misc;
  logic [1:0] txc;
  logic [1:0] rxc;
  logic       bit_tick;
  logic       tx_busy;

  // Bit 7 is never looked at
  assign misc = link.cmd_data[sccd_pkg::MISC_LSB +: sccd_pkg::MISC_W];
  assign txc  = link.cmd_data[sccd_pkg::TXC_LSB +: sccd_pkg::FLD_W];
  assign rxc  = link.cmd_data[sccd_pkg::RXC_LSB +: sccd_pkg::FLD_W];
  assign bit_tick = (st_r.div == 16'(BIT_DIV - 1));
  assign tx_busy  = tx_shifting || tx_holding;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pulses = '0;
    st_nxt.div = bit_tick ? 16'h0000 : st_r.div + 16'h0001;
    // Stop takes effect once the current character has gone
    if (st_r.tx_stop && !tx_shifting) begin
      st_nxt.tx_en = 1'b0;
      st_nxt.tx_stop = 1'b0;
    end
    // Break sequencer, stepped on bit boundaries; commands below win over a tick
    case (st_r.brk)
      BRK_IDLE: st_nxt.txd = tx_serial_in;
      BRK_WAIT: begin
        st_nxt.txd = tx_serial_in;
        if (bit_tick && !tx_busy) begin
          st_nxt.brk = sccd_brk_e'(BRK_ON);
        end
      end
      BRK_ON: st_nxt.txd = 1'b0;
      BRK_MARK: begin
        st_nxt.txd = 1'b1;
        st_nxt.mark = 1'b1;
        if (bit_tick) begin
          st_nxt.bits = st_r.bits + 2'h1;
          if (st_r.bits == 2'(sccd_pkg::BREAK_BITS - 1)) begin
            st_nxt.brk = sccd_brk_e'(BRK_IDLE);
            st_nxt.mark = 1'b0;
          end
        end
      end
      default: st_nxt.brk = sccd_brk_e'(BRK_IDLE);
    endcase
    if (link.cmd_wr) begin
      // Every field is decoded from the same word in one cycle
      case (misc)
        sccd_pkg::MISC_PTR_RESET: st_nxt.pulses[0] = 1'b1;
        sccd_pkg::MISC_RX_RESET: begin
          st_nxt.pulses[1] = 1'b1;
          st_nxt.pulses[2] = 1'b1;
          st_nxt.pulses[3] = 1'b1;
          st_nxt.pulses[4] = 1'b1;
          st_nxt.rx_en = 1'b0;
          st_nxt.rx_act = multidrop || loopback;
        end
        sccd_pkg::MISC_TX_RESET: begin
          st_nxt.pulses[5] = 1'b1;
          st_nxt.pulses[6] = 1'b1;
          st_nxt.pulses[7] = 1'b1;
          st_nxt.tx_en = 1'b0;
          st_nxt.tx_stop = 1'b0;
        end
        sccd_pkg::MISC_ERR_CLR: st_nxt.pulses[8] = 1'b1;
        sccd_pkg::MISC_BRK_CLR: st_nxt.pulses[9] = 1'b1;
        sccd_pkg::MISC_BRK_START: begin
          st_nxt.brk = sccd_brk_e'(BRK_WAIT);
          st_nxt.bits = '0;
          st_nxt.mark = 1'b0;
        end
        sccd_pkg::MISC_BRK_STOP: begin
          if (st_r.brk != BRK_IDLE) begin
            st_nxt.brk = sccd_brk_e'(BRK_MARK);
            st_nxt.bits = '0;
            st_nxt.mark = 1'b1;
          end
        end
        default: ;
      endcase
      case (txc)
        sccd_pkg::FC_ENABLE: begin
          st_nxt.tx_en = 1'b1;
          st_nxt.tx_stop = 1'b0;
        end
        sccd_pkg::FC_DISABLE: begin
          st_nxt.pulses[6] = 1'b1;
          st_nxt.pulses[7] = 1'b1;
          st_nxt.tx_stop = st_nxt.tx_en;
        end
        default: ;
      endcase
      case (rxc)
        sccd_pkg::FC_ENABLE: begin
          st_nxt.rx_en = 1'b1;
          st_nxt.rx_act = 1'b1;
          st_nxt.pulses[10] = !multidrop;
        end
        sccd_pkg::FC_DISABLE: begin
          st_nxt.rx_en = 1'b0;
          st_nxt.rx_act = multidrop || loopback;
          st_nxt.pulses[11] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{pulses: '0, tx_en: 1'b0, tx_stop: 1'b0, rx_en: 1'b0, rx_act: 1'b0,
                mark: 1'b0, txd: 1'b1, brk: BRK_IDLE, bits: '0, div: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mode_ptr_reset_r             = st_r.pulses[0];
  assign rx_reset_r                   = st_r.pulses[1];
  assign receive_ready_flag_clr_r     = st_r.pulses[2];
  assign receive_fifo_full_flag_clr_r = st_r.pulses[3];
  assign receive_queue_ptr_reset_r    = st_r.pulses[4];
  assign tx_reset_r                   = st_r.pulses[5];
  assign transmit_ready_flag_clr_r    = st_r.pulses[6];
  assign transmit_empty_flag_clr_r    = st_r.pulses[7];
  assign error_flags_clr_r            = st_r.pulses[8];
  assign break_change_clr_r           = st_r.pulses[9];
  assign rx_hunt_start_r              = st_r.pulses[10];
  assign rx_discard_r                 = st_r.pulses[11];
  assign tx_enable_r                  = st_r.tx_en;
  assign tx_stop_pending_r            = st_r.tx_stop;
  assign rx_enable_r                  = st_r.rx_en;
  assign rx_active_r                  = st_r.rx_act;
  assign tx_hold_mark_r               = st_r.mark;
  assign serial_transmit_output_r     = st_r.txd;

endmodule

// >>> sccd_assertions.sv
`timescale 1ns/1ps
module sccd_assertions (
  // Clock, reset and link
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_data,
  // Decoder outputs
  input wire logic       mode_ptr_reset_r,
  input wire logic       rx_reset_r,
  input wire logic       tx_reset_r,
  input wire logic       error_flags_clr_r,
  input wire logic       break_change_clr_r,
  input wire logic       rx_discard_r,
  input wire logic       tx_enable_r,
  input wire logic       tx_stop_pending_r,
  input wire logic       rx_enable_r
);
  wire [2:0] m = cmd_data[6:4];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_ptr_reset: assert property (cmd_wr && m == 3'h1 |=> mode_ptr_reset_r)
    else $error("pointer reset pulse missing");
  a_rx_reset: assert property (cmd_wr && m == 3'h2 |=> rx_reset_r && !rx_enable_r)
    else $error("receiver reset wrong");
  a_tx_reset: assert property (cmd_wr && m == 3'h3 |=> tx_reset_r && !tx_enable_r)
    else $error("transmitter reset wrong");
  a_err_clear_once: assert property (error_flags_clr_r == $past(cmd_wr && m == 3'h4))
    else $error("error clear pulse wrong");
  a_brk_clear_once: assert property (break_change_clr_r |-> $past(cmd_wr && m == 3'h5))
    else $error("break change clear without cause");
  a_tx_enable: assert property (cmd_wr && cmd_data[3:2] == 2'h1 |=> tx_enable_r)
    else $error("transmitter not enabled");
  a_rx_enable: assert property (cmd_wr && cmd_data[1:0] == 2'h1 |=> rx_enable_r)
    else $error("receiver not enabled");
  a_rx_disable: assert property (cmd_wr && cmd_data[1:0] == 2'h2 |=> !rx_enable_r && rx_discard_r)
    else $error("receiver disable wrong");
  a_idle_holds: assert property (cmd_wr && cmd_data[6:0] == 7'h0 && !tx_stop_pending_r
    |=> $stable(tx_enable_r) && $stable(rx_enable_r))
    else $error("idle command changed an enable");

  c_brk_start: cover property (cmd_wr && m == 3'h6);
  c_both_on: cover property (tx_enable_r && rx_enable_r);
  c_rx_drop: cover property (rx_discard_r);
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk, srst, wr, rd, multidrop, loopback, tx_shifting, tx_holding, tx_serial_in;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic illegal_r, mode_ptr_reset_r, rx_reset_r, tx_reset_r, error_flags_clr_r;
  logic break_change_clr_r, rx_hunt_start_r, rx_discard_r, tx_enable_r, tx_stop_pending_r;
  logic rx_enable_r, rx_active_r, transmit_ready_flag_clr_r, serial_transmit_output_r;
  logic receive_ready_flag_clr_r, receive_fifo_full_flag_clr_r, receive_queue_ptr_reset_r;
  logic transmit_empty_flag_clr_r, tx_hold_mark_r;
  wire [2:0] rx_flags = {receive_ready_flag_clr_r, receive_fifo_full_flag_clr_r,
                         receive_queue_ptr_reset_r};
  wire [1:0] tx_flags = {transmit_ready_flag_clr_r, transmit_empty_flag_clr_r};
  int n_mismatch = 0;
  int n_tests = 0;
  wire [4:0] pulses = {mode_ptr_reset_r, rx_reset_r, tx_reset_r, error_flags_clr_r,
                       break_change_clr_r};

  sccd_if link ();
  sccd_host i_sccd_host (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .illegal_r, .link(link));
  sccd_dev #(.BIT_DIV(4)) i_sccd_dev (.clk, .srst, .link(link), .multidrop, .loopback,
    .tx_shifting, .tx_holding, .tx_serial_in, .mode_ptr_reset_r, .rx_reset_r,
    .receive_ready_flag_clr_r, .receive_fifo_full_flag_clr_r, .receive_queue_ptr_reset_r,
    .tx_reset_r, .transmit_ready_flag_clr_r, .transmit_empty_flag_clr_r, .error_flags_clr_r,
    .break_change_clr_r, .rx_hunt_start_r, .rx_discard_r, .tx_enable_r, .tx_stop_pending_r,
    .rx_enable_r, .rx_active_r, .tx_hold_mark_r, .serial_transmit_output_r);
  sccd_assertions i_sccd_assertions (.clk, .srst, .cmd_wr(link.cmd_wr),
    .cmd_data(link.cmd_data), .mode_ptr_reset_r, .rx_reset_r, .tx_reset_r, .error_flags_clr_r,
    .break_change_clr_r, .rx_discard_r, .tx_enable_r, .tx_stop_pending_r, .rx_enable_r);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Write, then land just after the decoder's answer edge
  task automatic wr_cmd(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_txd(input logic lvl);
    for (int i = 0; i < 12; i++) begin
      if (serial_transmit_output_r === lvl) break;
      @(posedge clk);
      #1;
    end
    `CHK("txd", lvl, serial_transmit_output_r)
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {srst, wr, rd, addr, wdata} = {1'b1, 14'h0};
    {multidrop, loopback, tx_shifting, tx_holding, tx_serial_in} = 5'h01;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("reset", 8'h01, {pulses, tx_enable_r, rx_enable_r, serial_transmit_output_r})
    for (int c = 1; c < 6; c++) begin
      wr_cmd(4'h0, {c[0], c[2:0], 4'h0});
      `CHK("misc pulse", 5'h10 >> (c - 1), pulses)
      `CHK("rx flags", (c == 2) ? 3'h7 : 3'h0, rx_flags)
      `CHK("tx flags", (c == 3) ? 2'h3 : 2'h0, tx_flags)
      @(posedge clk);
      #1;
      `CHK("pulse end", 5'h00, pulses)
    end
    $display("test misc codes done");
    wr_cmd(4'h0, 8'h05);
    `CHK("enables", 3'h7, {tx_enable_r, rx_enable_r, rx_hunt_start_r})
    wr_cmd(4'h0, 8'h80);
    `CHK("idle", 2'h3, {tx_enable_r, rx_enable_r})
    rd_reg(4'h3, v);
    `CHK("readback", 8'h80, v)
    rd_reg(4'h1, v);
    `CHK("unmapped", 8'h00, v)
    $display("test enables done");
    @(posedge clk);
    loopback <= 1'b1;
    wr_cmd(4'h0, 8'h02);
    `CHK("rx off", 3'h3, {rx_enable_r, rx_discard_r, rx_active_r})
    @(posedge clk);
    tx_shifting <= 1'b1;
    wr_cmd(4'h0, 8'h08);
    `CHK("tx stop", 4'hf, {tx_enable_r, tx_stop_pending_r, tx_flags})
    @(posedge clk);
    tx_shifting <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("tx off", 1'b0, tx_enable_r)
    $display("test disables done");
    wr_cmd(4'h0, 8'h20);
    @(posedge clk);
    multidrop <= 1'b1;
    wr_cmd(4'h0, 8'h01);
    `CHK("hunt", 2'h2, {rx_enable_r, rx_hunt_start_r})
    wr_cmd(4'h0, 8'h20);
    `CHK("rx kept", 3'h3, {rx_enable_r, rx_reset_r, rx_active_r})
    wr_cmd(4'h0, 8'h40);
    `CHK("err clear", 1'b1, error_flags_clr_r)
    $display("test multidrop done");
    wr_cmd(4'h0, 8'h07);
    `CHK("refused", 2'h2, {illegal_r, tx_enable_r})
    wr_cmd(4'h0, 8'h04);
    `CHK("accepted", 2'h1, {illegal_r, tx_enable_r})
    $display("test refusal done");
    wr_cmd(4'h0, 8'h60);
    wait_txd(1'b0);
    @(posedge clk);
    tx_serial_in <= 1'b0;
    wr_cmd(4'h0, 8'h70);
    `CHK("mark flag", 1'b1, tx_hold_mark_r)
    wait_txd(1'b1);
    repeat (3) @(posedge clk);
    #1;
    `CHK("mark held", 1'b1, serial_transmit_output_r)
    wait_txd(1'b0);
    `CHK("mark end", 1'b0, tx_hold_mark_r)
    $display("test break done");
    @(posedge clk);
    tx_serial_in <= 1'b1;
    tx_holding <= 1'b1;
    wr_cmd(4'h0, 8'h60);
    repeat (6) @(posedge clk);
    #1;
    `CHK("break held", 1'b1, serial_transmit_output_r)
    @(posedge clk);
    tx_holding <= 1'b0;
    wait_txd(1'b0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("mid reset", 3'h0, {tx_enable_r, rx_enable_r, tx_hold_mark_r})
    `CHK("mid txd", 1'b1, serial_transmit_output_r)
    $display("test hold-off done");
    end_of_test();
  end
endmodule
